// File: src/ssr_supervisor.sv
// Purpose: supply supervisor reset sequencing and voltage detector interrupts
// Assumes: analog comparators arrive as levels; compare output is asynchronous
// Notes: outputs all registered; interrupt is level, clear by write-one

`timescale 1ns/10ps

module ssr_supervisor
    import ssr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic supervisor_enable_pin,
    input wire logic ext_reset_n,
    input wire logic por_ok,
    input wire logic bor_ok_lvl1,
    input wire logic bor_ok_lvl2,
    input wire logic bor_ok_lvl3,
    input wire logic opt_load_done,
    input wire logic [1:0] opt_brownout_sel,
    input wire logic detector_cmp_async,
    input wire ssr_bus_s bus_in,
    output logic [31:0] rdata,
    output logic chip_reset_n,
    output logic opt_load_start,
    output logic detector_on,
    output logic [2:0] detector_level_select,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // sequencing state

    ssr_state_e state_reg;
    ssr_state_e state_next;
    logic [1:0] bor_sel_reg;
    logic [7:0] settle_cnt_reg;
    logic [7:0] rel_cnt_reg;
    logic chip_reset_n_reg;
    logic opt_load_start_reg;

    logic [7:0] ctrl_reg;
    logic [ST_W-1:0] status_reg;
    logic [ST_W-1:0] irq_en_reg;
    logic [31:0] rdata_reg;
    logic irq_reg;
    logic det_on_reg;
    logic [2:0] lvl_reg;

    ////////////////////////////////////////////////////////////////////////
    // undervoltage decode

    function automatic logic bor_ok_sel(input logic [1:0] sel, input logic l1,
                                        input logic l2, input logic l3);
        case (sel)
            2'h0: bor_ok_sel = l1;
            2'h1: bor_ok_sel = l2;
            2'h2: bor_ok_sel = l3;
            default: bor_ok_sel = 1'b1;
        endcase
    endfunction

    wire internal_on = supervisor_enable_pin;
    // brownout only counts once options are loaded and not disabled
    wire bor_active = (state_reg == SSR_RUN) && (bor_sel_reg != BOR_OFF);
    wire bor_ok = bor_ok_sel(bor_sel_reg, bor_ok_lvl1, bor_ok_lvl2, bor_ok_lvl3);
    wire bor_low = bor_active && !bor_ok;
    // por is never masked by options or software
    wire int_undervolt = !por_ok || bor_low;
    wire supply_low = internal_on ? int_undervolt : !ext_reset_n;
    wire release_ok = (state_reg == SSR_RUN) && !supply_low && (rel_cnt_reg == 8'h00);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SSR_POR: begin
                if (!supply_low && settle_cnt_reg == 8'h00) begin
                    state_next = SSR_LOAD;
                end
            end
            SSR_LOAD: begin
                if (supply_low) begin
                    state_next = SSR_POR;
                end else if (opt_load_done) begin
                    state_next = SSR_RUN;
                end
            end
            SSR_RUN: begin
                if (internal_on && !por_ok) begin
                    state_next = SSR_POR;
                end
            end
            default: state_next = SSR_POR;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= SSR_POR;
            settle_cnt_reg <= 8'(OPT_SETTLE_CYC);
        end else begin
            state_reg <= state_next;
            if (state_reg != SSR_POR || supply_low) begin
                settle_cnt_reg <= 8'(OPT_SETTLE_CYC);
            end else if (settle_cnt_reg != 8'h00) begin
                settle_cnt_reg <= settle_cnt_reg - 8'h01;
            end
        end
    end

    // option field is captured once per load; software cannot touch it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bor_sel_reg <= BOR_OFF;
            opt_load_start_reg <= 1'b0;
        end else begin
            opt_load_start_reg <= (state_reg == SSR_POR) && (state_next == SSR_LOAD);
            if (state_reg == SSR_LOAD && opt_load_done) begin
                bor_sel_reg <= opt_brownout_sel;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rel_cnt_reg <= 8'(REL_DELAY_CYC);
            chip_reset_n_reg <= 1'b0;
        end else begin
            if (supply_low || state_reg != SSR_RUN) begin
                rel_cnt_reg <= 8'(REL_DELAY_CYC);
            end else if (rel_cnt_reg != 8'h00) begin
                rel_cnt_reg <= rel_cnt_reg - 8'h01;
            end
            chip_reset_n_reg <= release_ok && !supply_low;
        end
    end

    // basic hold of the chip reset
    a_reset_held: assert property (@(posedge core_clk) disable iff (!rst_n)
        supply_low |=> !chip_reset_n)
        else $error("reset released while supply low");
    a_por_unmasked: assert property (@(posedge core_clk) disable iff (!rst_n)
        (internal_on && !por_ok) |=> !chip_reset_n)
        else $error("por ignored");
    a_ext_reset_path: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!internal_on && !ext_reset_n) |=> !chip_reset_n)
        else $error("ext reset lost");
    a_load_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        opt_load_start |-> state_reg == SSR_LOAD)
        else $error("load start off state");
    a_bor_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bor_sel_reg == BOR_OFF) |-> !bor_low)
        else $error("disabled brownout acted");

    // load handshake: done in load, supply fine, then run with the new field
    sequence s_load_ends;
        state_reg == SSR_LOAD && opt_load_done && !supply_low;
    endsequence

    sequence s_run_with_sel;
        state_reg == SSR_RUN && bor_sel_reg == $past(opt_brownout_sel);
    endsequence

    // the pin alone picks which supervisor counts
    a_pin_overrides: assert property (@(posedge core_clk) disable iff (!rst_n)
        (supervisor_enable_pin && !ext_reset_n && !int_undervolt && state_reg == SSR_RUN
            && rel_cnt_reg == 8'h00) |=> chip_reset_n)
        else $error("external reset obeyed while internal on");
    a_ext_release: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!supervisor_enable_pin && ext_reset_n && state_reg == SSR_RUN
            && rel_cnt_reg == 8'h00) |=> chip_reset_n)
        else $error("internal supervisor acted while off");
    a_run_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_reg != SSR_RUN) |=> !chip_reset_n)
        else $error("reset released before options loaded");
    a_por_return: assert property (@(posedge core_clk) disable iff (!rst_n)
        (internal_on && !por_ok) |=> state_reg == SSR_POR)
        else $error("por loss did not restart sequence");

    // a short glitch must restart the settle count, not resume it
    a_settle_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
        opt_load_start |-> $past(settle_cnt_reg == 8'h00))
        else $error("load started before settle");
    a_start_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
        opt_load_start |=> !opt_load_start)
        else $error("load start longer than one cycle");
    a_settle_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
        supply_low |=> settle_cnt_reg == 8'(OPT_SETTLE_CYC))
        else $error("settle count not restarted");
    a_load_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_reg == SSR_LOAD && supply_low) |=> state_reg == SSR_POR)
        else $error("load kept through supply loss");
    a_load_to_run: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_load_ends |=> s_run_with_sel)
        else $error("option load not applied");
    a_sel_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(state_reg == SSR_LOAD && opt_load_done) |=> $stable(bor_sel_reg))
        else $error("brownout level changed outside load");

    // release only once the delay has run out
    a_release_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(chip_reset_n) |-> $past(rel_cnt_reg == 8'h00))
        else $error("reset released early");

    ////////////////////////////////////////////////////////////////////////
    // voltage detector

    logic cmp_level;
    logic cmp_rise;
    logic cmp_fall;

    ssr_edge_det u_edge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(detector_cmp_async),
        .level(cmp_level),
        .rise(cmp_rise),
        .fall(cmp_fall)
    );

    // compare high means supply below threshold
    wire det_en = ctrl_reg[CTRL_DET_EN];
    wire fall_evt = det_en && ctrl_reg[CTRL_FALL_EN] && cmp_rise;
    wire rise_evt = det_en && ctrl_reg[CTRL_RISE_EN] && cmp_fall;
    wire bor_evt = bor_low;

    ////////////////////////////////////////////////////////////////////////
    // register port

    wire wr_ctrl = bus_in.wr && bus_in.addr == ADDR_CTRL;
    wire wr_clear = bus_in.wr && bus_in.addr == ADDR_CLEAR;
    wire wr_irq_en = bus_in.wr && bus_in.addr == ADDR_IRQ_EN;
    wire [ST_W-1:0] evt_vec = {bor_evt, rise_evt, fall_evt};
    wire [ST_W-1:0] clr_vec = wr_clear ? bus_in.wdata[ST_W-1:0] : '0;

    wire [31:0] rd_mux = (bus_in.addr == ADDR_CTRL) ? {24'h0, ctrl_reg} :
                         (bus_in.addr == ADDR_STATUS) ? {28'h0, cmp_level, status_reg} :
                         (bus_in.addr == ADDR_IRQ_EN) ? {29'h0, irq_en_reg} : 32'h0;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
            irq_en_reg <= IRQ_EN_RESET;
            rdata_reg <= 32'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= bus_in.wdata[7:0];
            end
            if (wr_irq_en) begin
                irq_en_reg <= bus_in.wdata[ST_W-1:0];
            end
            rdata_reg <= bus_in.rd ? rd_mux : 32'h0;
        end
    end

    // per-bit sticky flags; a new event beats a simultaneous clear
    genvar gi;
    generate
        for (gi = 0; gi < ST_W; gi++) begin : g_flag
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    status_reg[gi] <= 1'b0;
                end else if (evt_vec[gi]) begin
                    status_reg[gi] <= 1'b1;
                end else if (clr_vec[gi]) begin
                    status_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
            det_on_reg <= 1'b0;
            lvl_reg <= 3'h0;
        end else begin
            irq_reg <= |(status_reg & irq_en_reg);
            det_on_reg <= det_en;
            lvl_reg <= ctrl_reg[CTRL_LVL_LSB +: 3];
        end
    end

    a_det_silent: assert property (@(posedge core_clk) disable iff (!rst_n)
        !det_en |=> !$rose(status_reg[ST_FALL]) && !$rose(status_reg[ST_RISE]))
        else $error("detector flag while disabled");
    a_fall_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        fall_evt |=> status_reg[ST_FALL])
        else $error("falling event lost");
    a_level_field: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ctrl ##2 1'b1 |-> detector_level_select == $past(bus_in.wdata[6:4], 2))
        else $error("level field not applied");

    // flag and interrupt path; a clear must never swallow a fresh event
    a_rise_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        rise_evt |=> status_reg[ST_RISE])
        else $error("rising event lost");
    a_bor_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        bor_evt |=> status_reg[ST_BOR_EVT])
        else $error("brownout event lost");
    a_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fall_evt && clr_vec[ST_FALL]) |=> status_reg[ST_FALL])
        else $error("clear beat a new event");
    a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        (status_reg[ST_FALL] && !clr_vec[ST_FALL]) |=> status_reg[ST_FALL])
        else $error("flag dropped without clear");
    a_irq_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
        (|(status_reg & irq_en_reg)) |=> irq)
        else $error("enabled flag without interrupt");
    a_irq_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(|(status_reg & irq_en_reg)) |=> !irq)
        else $error("interrupt without enabled flag");

    // control outputs trail the register by one cycle
    a_det_out: assert property (@(posedge core_clk) disable iff (!rst_n)
        !det_en |=> !detector_on)
        else $error("detector shown on while disabled");
    a_ctrl_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ctrl |=> ##1 detector_on == $past(bus_in.wdata[CTRL_DET_EN], 2))
        else $error("enable bit not applied");

    assign rdata = rdata_reg;
    assign chip_reset_n = chip_reset_n_reg;
    assign opt_load_start = opt_load_start_reg;
    assign detector_on = det_on_reg;
    assign detector_level_select = lvl_reg;
    assign irq = irq_reg;

endmodule // ssr_supervisor

// File: src/ssr_pkg.sv
// Purpose: shared constants and types of the supply supervisor reset control
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: register map reached over the plain strobe port
package ssr_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    // option load settle time before the load is sampled
    localparam int unsigned OPT_SETTLE_NS = 100;
    localparam int unsigned OPT_SETTLE_CYC = (OPT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // release delay after the undervoltage indication clears
    localparam int unsigned REL_DELAY_NS = 200;
    localparam int unsigned REL_DELAY_CYC = (REL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_CLEAR = 4'h8;
    localparam logic [3:0] ADDR_IRQ_EN = 4'hc;

    localparam int unsigned CTRL_DET_EN = 0;
    localparam int unsigned CTRL_FALL_EN = 1;
    localparam int unsigned CTRL_RISE_EN = 2;
    localparam int unsigned CTRL_LVL_LSB = 4;

    localparam int unsigned ST_FALL = 0;
    localparam int unsigned ST_RISE = 1;
    localparam int unsigned ST_BOR_EVT = 2;
    localparam int unsigned ST_W = 3;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] IRQ_EN_RESET = 3'h0;

    // option field: 2'b11 disables brownout reset until the next option load
    localparam logic [1:0] BOR_OFF = 2'h3;

    typedef enum {SSR_POR, SSR_LOAD, SSR_RUN} ssr_state_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ssr_bus_s;

endpackage

// File: src/ssr_edge_det.sv
// Purpose: synchronise the asynchronous compare output and find its edges
// Assumes: core_clk domain, synchronous active-low reset
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module ssr_edge_det
    import ssr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);

    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise = sync_reg & ~prev_reg;
    assign fall = ~sync_reg & prev_reg;

    a_sync_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
        rise |-> $past(meta_reg))
        else $error("edge seen without synchroniser");

endmodule // ssr_edge_det

// File: dv/ssr_supply_model.sv
// Purpose: far side of the supervisor: supply rails, external supervisor, option store
// Assumes: supply level given in millivolts by the bench
// Notes: thresholds are plain defaults, not figures of any real part
`timescale 1ns/10ps
module ssr_supply_model
    import ssr_pkg::*;
#(
    parameter int POR_MV = 1700,
    parameter int BOR1_MV = 2200,
    parameter int BOR2_MV = 2500,
    parameter int BOR3_MV = 2800,
    parameter int DET_MV = 2100,
    parameter int DET_STEP = 150
) (
    input wire logic core_clk,
    input wire logic [11:0] vdd_mv,
    input wire logic ext_hold,
    input wire logic [3:0] load_lat,
    input wire logic opt_load_start,
    input wire logic [2:0] detector_level_select,
    output logic por_ok,
    output logic bor_ok_lvl1,
    output logic bor_ok_lvl2,
    output logic bor_ok_lvl3,
    output logic ext_reset_n,
    output logic opt_load_done,
    output logic detector_cmp_async
);
    int cnt = 0;
    assign por_ok = vdd_mv >= POR_MV;
    assign bor_ok_lvl1 = vdd_mv >= BOR1_MV;
    assign bor_ok_lvl2 = vdd_mv >= BOR2_MV;
    assign bor_ok_lvl3 = vdd_mv >= BOR3_MV;
    // external supervisor holds reset while the supply is low
    assign ext_reset_n = por_ok && !ext_hold;
    // analog compare, deliberately off the clock grid
    assign #3 detector_cmp_async = vdd_mv < DET_MV + DET_STEP * detector_level_select;
    initial opt_load_done = 1'b0;
    // option store answers after a bench-chosen latency, prompt or slow
    always @(posedge core_clk) begin
        opt_load_done <= (cnt == 1);
        if (opt_load_start === 1'b1) begin
            cnt <= load_lat + 1;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule // ssr_supply_model

// File: dv/ssr_supervisor_test.sv
// Purpose: self-checking bench of the supply supervisor reset control
// Assumes: bus tasks start right after a rising edge
// Notes: brownout is switched off by option before the detector phase
`timescale 1ns/10ps
module ssr_supervisor_test;
    import ssr_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic supervisor_enable_pin = 1'b1;
    logic ext_hold = 1'b0;
    logic [11:0] vdd_mv = 12'h000;
    logic [3:0] load_lat = 4'h1;
    logic [1:0] opt_brownout_sel = 2'h0;
    ssr_bus_s bus = '0;
    logic por_ok, bor_ok_lvl1, bor_ok_lvl2, bor_ok_lvl3, ext_reset_n, opt_load_done;
    logic detector_cmp_async, chip_reset_n, opt_load_start, detector_on, irq;
    logic [2:0] detector_level_select;
    logic [31:0] rdata;
    int n_fail = 0;
    int checked = 0;
    int n_start = 0;
    int bor_mv [3] = '{2200, 2500, 2800};
    int m;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (opt_load_start === 1'b1) n_start++;
    ssr_supervisor ssr_supervisor_i (.core_clk(core_clk), .rst_n(rst_n),
        .supervisor_enable_pin(supervisor_enable_pin), .ext_reset_n(ext_reset_n),
        .por_ok(por_ok), .bor_ok_lvl1(bor_ok_lvl1), .bor_ok_lvl2(bor_ok_lvl2),
        .bor_ok_lvl3(bor_ok_lvl3), .opt_load_done(opt_load_done),
        .opt_brownout_sel(opt_brownout_sel), .detector_cmp_async(detector_cmp_async),
        .bus_in(bus), .rdata(rdata), .chip_reset_n(chip_reset_n),
        .opt_load_start(opt_load_start), .detector_on(detector_on),
        .detector_level_select(detector_level_select), .irq(irq));
    ssr_supply_model ssr_supply_model_i (.core_clk(core_clk), .vdd_mv(vdd_mv),
        .ext_hold(ext_hold), .load_lat(load_lat), .opt_load_start(opt_load_start),
        .detector_level_select(detector_level_select), .por_ok(por_ok),
        .bor_ok_lvl1(bor_ok_lvl1), .bor_ok_lvl2(bor_ok_lvl2), .bor_ok_lvl3(bor_ok_lvl3),
        .ext_reset_n(ext_reset_n), .opt_load_done(opt_load_done),
        .detector_cmp_async(detector_cmp_async));
    ////////////////////////////////////////////////////////////////////////////
    task end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge core_clk);
        bus.wr <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] mask);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 chk("rdata", exp, rdata & mask);
        @(posedge core_clk);
    endtask
    task wait_rst(input logic exp, input int bound);
        #1;
        for (int i = 0; i < bound && chip_reset_n !== exp; i++) begin
            @(posedge core_clk);
            #1;
        end
        chk("chip_reset_n", exp, chip_reset_n);
        if (chip_reset_n !== exp) end_of_test();
        @(posedge core_clk);
    endtask
    // supply step to 3300 mV: count cycles from the load answer to the release
    task power_up(input int lat);
        int n;
        int s0;
        n = 99;
        s0 = n_start;
        load_lat <= 4'(lat);
        vdd_mv <= 12'hce4;
        for (int i = 0; i < 200 && chip_reset_n !== 1'b1; i++) begin
            @(posedge core_clk);
            #1 n = (opt_load_done === 1'b1) ? 0 : n + 1;
        end
        chk("load starts", s0 + 1, n_start);
        chk("release gap", 1, n >= REL_DELAY_CYC && n <= REL_DELAY_CYC + 2);
        wait_rst(1'b1, 1);
    endtask
    task fall_rise(input int lv);
        vdd_mv <= 12'(2100 + 150 * lv - $urandom_range(90, 1));
        repeat (6) @(posedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(84297));
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge core_clk);
        chk("chip_reset_n", 1'b0, chip_reset_n);
        chk("load starts", 0, n_start);
        rd(ADDR_CTRL, {24'h0, CTRL_RESET}, 32'hffffffff);
        rd(ADDR_IRQ_EN, {29'h0, IRQ_EN_RESET}, 32'hffffffff);
        wr(4'h2, 32'h5a5a5a5a);
        rd(4'h2, 32'h0, 32'hffffffff);
        power_up(1);
        for (int s = 0; s < 4; s++) begin
            opt_brownout_sel <= 2'(s);
            vdd_mv <= 12'h3e8;
            wait_rst(1'b0, 5);
            power_up($urandom_range(12, 1));
            vdd_mv <= 12'($urandom_range(3299, s == 3 ? 1700 : bor_mv[s]));
            repeat (30) @(posedge core_clk);
            chk("chip_reset_n", 1'b1, chip_reset_n);
            if (s < 3) begin
                vdd_mv <= 12'($urandom_range(bor_mv[s] - 1, s == 0 ? 1700 : bor_mv[s - 1]));
                wait_rst(1'b0, 5);
                rd(ADDR_STATUS, 32'h4, 32'h4);
            end
        end
        supervisor_enable_pin <= 1'b0;
        vdd_mv <= 12'hce4;
        ext_hold <= 1'b1;
        wait_rst(1'b0, 10);
        ext_hold <= 1'b0;
        wait_rst(1'b1, 100);
        vdd_mv <= 12'h3e8;
        wait_rst(1'b0, 10);
        vdd_mv <= 12'hce4;
        wait_rst(1'b1, 100);
        supervisor_enable_pin <= 1'b1;
        ext_hold <= 1'b1;
        wait_rst(1'b1, 100);
        repeat (10) @(posedge core_clk);
        chk("chip_reset_n", 1'b1, chip_reset_n);
        ext_hold <= 1'b0;
        wr(ADDR_CLEAR, 32'h7);
        wr(ADDR_IRQ_EN, 32'h7);
        wr(ADDR_CTRL, 32'h76);
        fall_rise(7);
        vdd_mv <= 12'hce4;
        repeat (8) @(posedge core_clk);
        chk("irq", 1'b0, irq);
        chk("detector_on", 1'b0, detector_on);
        rd(ADDR_STATUS, 32'h0, 32'h3);
        for (int k = 0; k < 8; k++) begin
            m = k & 3;
            wr(ADDR_CTRL, 32'(k << 4) | 32'(m << 1) | 32'h1);
            chk("detector_level_select", 32'(k), detector_level_select);
            chk("detector_on", 1'b1, detector_on);
            fall_rise(k);
            chk("irq fall", 32'(m & 1), irq);
            rd(ADDR_STATUS, 32'h8, 32'h8);
            wr(ADDR_CLEAR, 32'h7);
            vdd_mv <= 12'(2100 + 150 * k + $urandom_range(90, 1));
            repeat (6) @(posedge core_clk);
            chk("irq rise", 32'(m >> 1), irq);
            if (k == 7) begin
                wr(ADDR_IRQ_EN, 32'h0);
                chk("irq masked", 1'b0, irq);
                rd(ADDR_STATUS, 32'h2, 32'h3);
                wr(ADDR_IRQ_EN, 32'h7);
                chk("irq unmasked", 1'b1, irq);
            end
            wr(ADDR_CLEAR, 32'h7);
            chk("irq cleared", 1'b0, irq);
        end
        end_of_test();
    end
endmodule // ssr_supervisor_test
